// *** odc_pkg.sv ***
package odc_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W   = 8;     // Byte address width
  localparam int          DATA_W   = 32;    // Data word width
  localparam logic [7:0]  OFS_CTRL = 8'h00; // Oscillator control register
  localparam logic [7:0]  OFS_KEY  = 8'h04; // Unlock key / lock status

  // Unlock keys, values are arbitrary
  localparam logic [31:0] KEY_FIRST  = 32'hC0DE_0A11;
  localparam logic [31:0] KEY_SECOND = 32'h0A11_C0DE;

  // ----------------------------------------------------------------
  // Field positions in the oscillator control and key registers
  // ----------------------------------------------------------------
  localparam int PLLDIV_LSB = 27; // PLL post-divider code, 3 bits
  localparam int FAST_RC_DIVIDER_LSB = 24; // Fast RC divider code, 3 bits
  localparam int SECONDARY_OSCILLATOR_BIT   = 22; // Secondary oscillator ready
  localparam int PBRDY_BIT  = 21; // Peripheral divisor ready
  localparam int PERIPH_BUS_DIVISOR_LSB  = 19; // Peripheral bus divisor, 2 bits
  localparam int MULT_LSB   = 16; // PLL multiplier, 3 bits
  localparam int NEW_OSCILLATOR_SELECT_LSB   = 8;  // New oscillator select, 3 bits
  localparam int UNLK_BIT   = 0;  // Unlocked flag in key register

  // ----------------------------------------------------------------
  // Reset values and counter geometry
  // ----------------------------------------------------------------
  localparam logic [2:0] FAST_RC_DIVIDER_RST = 3'h1; // Fast RC divided by two
  localparam logic [2:0] CODE_MAX   = 3'h7; // Code with the odd factor
  localparam int         CNT_W      = 8;    // Divider counter width
  localparam logic [7:0] LAST_MAX   = 8'hFF; // Factor 256 minus one
  localparam logic [7:0] ONE_CNT    = 8'h01; // Unit step

  // Configuration-derived fields, loaded at power-on reset
  typedef struct packed {
    logic [2:0] pllOutDiv;   // PLL post-divider code
    logic [2:0] pll_multiplier;     // PLL multiplier code
    logic [1:0] periph_bus_divisor;       // Peripheral bus divisor code
    logic [2:0] newOscSel;   // New oscillator select
  } odc_cfg_t;

  // Writable fields of the oscillator control register
  typedef struct packed {
    logic [2:0] pllOutDiv;   // PLL post-divider code
    logic [2:0] fast_rc_divider;      // Fast RC divider code
    logic [1:0] periph_bus_divisor;       // Peripheral bus divisor code
    logic [2:0] pll_multiplier;     // PLL multiplier code
    logic [2:0] newOscSel;   // New oscillator select
  } odc_ctrl_t;

  // Terminal count of a divider: factor minus one
  function automatic logic [7:0] odcLastCount(input logic [2:0] code);
    logic [7:0] lastCnt;
    lastCnt = (code == CODE_MAX) ? LAST_MAX
                                 : 8'((ONE_CNT << code) - ONE_CNT);
    return lastCnt;
  endfunction

endpackage

// *** odc_oscillator_divider_control.sv ***
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Enable-pulse divider: one pulse every (lastCnt + 1) source ticks
// ------------------------------------------------------------------
module odc_clk_div #(
  parameter int W = 8                    // Counter width
) (
  input  wire logic         ref_clk,     // System clock
  input  wire logic         rst_n,       // Synchronous reset, low
  input  wire logic         clkEn,       // Freezes state while low
  input  wire logic         tick,        // Source clock tick
  input  wire logic         restart,     // Realign on a new factor
  input  wire logic [W-1:0] lastCnt,     // Factor minus one
  output logic              pulse        // One-cycle divided enable
);

  logic [W-1:0] cnt_reg;                 // Ticks seen this period
  logic         atEnd;                   // Period completes on tick

  assign atEnd = (cnt_reg == lastCnt);

  // Count ticks; a restart drops any half-done period
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      pulse   <= 1'b0;
    end else if (clkEn) begin
      if (restart) begin
        cnt_reg <= '0;
        pulse   <= 1'b0;
      end else if (tick) begin
        cnt_reg <= atEnd ? '0 : W'(cnt_reg + 1'b1);
        pulse   <= atEnd;
      end else begin
        pulse   <= 1'b0;
      end
    end
  end

endmodule

// Functional notes
// - PLL post-divider code selects 1..64 or 256
// - Fast RC divider same encoding, default 2
// - Bit 22 shows secondary oscillator ready
// - Bit 21 gates peripheral divisor writes
// - Peripheral clock is system clock over 1..8
// - Control writes need the unlock sequence
// - Bits 31-30 and 23 read zero
// - Power-on reset loads configuration-derived fields
module odc_oscillator_divider_control
  import odc_pkg::*;
(
  input  wire logic              ref_clk,       // System clock, 20 MHz
  input  wire logic              rst_n,         // Synchronous reset, low
  input  wire logic              clkEn,         // Freezes state while low
  input  wire logic [ADDR_W-1:0] addr,          // Register byte address
  input  wire logic [DATA_W-1:0] wrData,        // Write data
  input  wire logic              wrStrobe,      // Write strobe
  input  wire logic              rdStrobe,      // Read strobe
  output logic      [DATA_W-1:0] rdData,        // Read data, next cycle
  input  wire odc_cfg_t          cfg,           // Configuration bits
  input  wire logic              pllTick,       // PLL output tick
  input  wire logic              frcTick,       // Fast RC tick
  input  wire logic              secOscRunning, // Secondary osc stable
  output odc_ctrl_t              ctrlOut,       // Control fields
  output logic                   pllClkEn,      // Divided PLL enable
  output logic                   frcClkEn,      // Divided fast RC enable
  output logic                   periphClkEn,   // Peripheral bus enable
  output logic                   periphDivReady // Divisor may be written
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  odc_ctrl_t ctrl_reg;        // Control fields
  odc_ctrl_t ctrl_next;       // Control fields after a write
  logic      unlocked_reg;    // Unlock sequence completed
  logic      keyStage_reg;    // First key seen
  logic      pbRdy_reg;       // Peripheral divisor ready
  logic      pbRdy_next;      // Ready after this cycle

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire selCtrl   = (addr == OFS_CTRL);           // Control register
  wire selKey    = (addr == OFS_KEY);            // Key register
  wire wrKey     = wrStrobe && selKey;           // Key write
  wire wrCtrl    = wrStrobe && selCtrl;          // Any control write
  wire wrCtrlOk  = wrCtrl && unlocked_reg;
  wire [2:0] wPll  = wrData[PLLDIV_LSB +: 3];    // Written PLL code
  wire [2:0] wFrc  = wrData[FAST_RC_DIVIDER_LSB +: 3];    // Written RC code
  wire [1:0] wPb   = wrData[PERIPH_BUS_DIVISOR_LSB  +: 2];    // Written divisor
  wire [2:0] wMult = wrData[MULT_LSB   +: 3];    // Written multiplier
  wire [2:0] wNosc = wrData[NEW_OSCILLATOR_SELECT_LSB   +: 3];    // Written select

  // A divisor write only counts while ready, and only on a change
  wire pbWrOk   = wrCtrlOk && pbRdy_reg;
  wire pbChange = pbWrOk && (wPb != ctrl_reg.periph_bus_divisor);
  wire pllChange = wrCtrlOk && (wPll != ctrl_reg.pllOutDiv);
  wire frcChange = wrCtrlOk && (wFrc != ctrl_reg.fast_rc_divider);

  // Next control fields; locked writes leave all untouched
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wrCtrlOk) begin
      ctrl_next.pllOutDiv = wPll;
      ctrl_next.fast_rc_divider    = wFrc;
      ctrl_next.pll_multiplier   = wMult;
      ctrl_next.newOscSel = wNosc;
      if (pbWrOk) begin
        ctrl_next.periph_bus_divisor = wPb;
      end
    end
  end

  // Divisor stays not-ready from a change until the realigned pulse.
  // The write wins over a stale pulse, since that pulse belongs to
  // the period that the restart throws away.
  always_comb begin
    if (pbChange) begin
      pbRdy_next = 1'b0;
    end else if (periphClkEn) begin
      pbRdy_next = 1'b1;
    end else begin
      pbRdy_next = pbRdy_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrlWord;   // Control register image
  logic [DATA_W-1:0] keyWord;    // Key register image
  logic [DATA_W-1:0] rdMux;      // Selected read value

  always_comb begin
    ctrlWord = '0;
    ctrlWord[PLLDIV_LSB +: 3] = ctrl_reg.pllOutDiv;
    ctrlWord[FAST_RC_DIVIDER_LSB +: 3] = ctrl_reg.fast_rc_divider;
    ctrlWord[SECONDARY_OSCILLATOR_BIT]        = secOscRunning;
    ctrlWord[PBRDY_BIT]       = pbRdy_reg;
    ctrlWord[PERIPH_BUS_DIVISOR_LSB  +: 2] = ctrl_reg.periph_bus_divisor;
    ctrlWord[MULT_LSB   +: 3] = ctrl_reg.pll_multiplier;
    ctrlWord[NEW_OSCILLATOR_SELECT_LSB   +: 3] = ctrl_reg.newOscSel;
    keyWord = '0;
    keyWord[UNLK_BIT] = unlocked_reg;
  end

  assign rdMux = selCtrl ? ctrlWord : (selKey ? keyWord : '0);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset is synchronous, so configuration bits can be caught here
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_reg.pllOutDiv <= cfg.pllOutDiv;
      ctrl_reg.fast_rc_divider    <= FAST_RC_DIVIDER_RST;
      ctrl_reg.periph_bus_divisor     <= cfg.periph_bus_divisor;
      ctrl_reg.pll_multiplier   <= cfg.pll_multiplier;
      ctrl_reg.newOscSel <= cfg.newOscSel;
      pbRdy_reg          <= 1'b1;
    end else if (clkEn) begin
      ctrl_reg  <= ctrl_next;
      pbRdy_reg <= pbRdy_next;
    end
  end

  // Unlock: first key, then second key on the next key write.
  // Any other key write locks again, a cheap way back to safety.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      keyStage_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end else if (clkEn && wrKey) begin
      keyStage_reg <= (wrData == KEY_FIRST);
      unlocked_reg <= keyStage_reg && (wrData == KEY_SECOND);
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdData <= '0;
    end else if (clkEn) begin
      rdData <= rdStrobe ? rdMux : '0;
    end
  end

  assign ctrlOut        = ctrl_reg;
  assign periphDivReady = pbRdy_reg;

  // ----------------------------------------------------------------
  // Dividers, all as enables in the one clock domain
  // ----------------------------------------------------------------
  wire [7:0] pllLast = odcLastCount(ctrl_reg.pllOutDiv);
  wire [7:0] frcLast = odcLastCount(ctrl_reg.fast_rc_divider);
  wire [7:0] pbLast  = odcLastCount({1'b0, ctrl_reg.periph_bus_divisor});

  odc_clk_div #(.W(CNT_W)) uPllDiv (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .tick    (pllTick),
    .restart (pllChange),
    .lastCnt (pllLast),
    .pulse   (pllClkEn)
  );

  odc_clk_div #(.W(CNT_W)) uFrcDiv (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .tick    (frcTick),
    .restart (frcChange),
    .lastCnt (frcLast),
    .pulse   (frcClkEn)
  );

  // System clock ticks every cycle
  odc_clk_div #(.W(CNT_W)) uPbDiv (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .tick    (1'b1),
    .restart (pbChange),
    .lastCnt (pbLast),
    .pulse   (periphClkEn)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking

  AST_LOCKED_WRITE: assert property (
    disable iff (!rst_n) wrCtrl && !unlocked_reg |=> $stable(ctrl_reg))
    else $error("Locked write changed the control fields");

  AST_UNLOCK_SEQ: assert property (
    disable iff (!rst_n)
    clkEn && wrKey && wrData == KEY_FIRST ##1
    clkEn && wrKey && wrData == KEY_SECOND |=> unlocked_reg)
    else $error("Key sequence did not unlock");

  AST_RSVD_ZERO: assert property (
    disable iff (!rst_n) rdData[31:30] == 2'h0 && !rdData[23])
    else $error("Unimplemented bits read nonzero");

  AST_SECONDARY_OSCILLATOR_RDY: assert property (
    disable iff (!rst_n) clkEn && rdStrobe && selCtrl
    |=> rdData[SECONDARY_OSCILLATOR_BIT] == $past(secOscRunning))
    else $error("Ready bit does not follow the oscillator");

  AST_PB_BLOCK: assert property (
    disable iff (!rst_n) wrCtrl && !pbRdy_reg |=> $stable(ctrl_reg.periph_bus_divisor))
    else $error("Divisor written while not ready");

  AST_PB_DIV1: assert property (
    disable iff (!rst_n)
    clkEn && pbRdy_reg && ctrl_reg.periph_bus_divisor == 2'h0 && !pbChange
    |=> periphClkEn)
    else $error("Divide by one missed a pulse");

  AST_PULSE_ONE: assert property (
    disable iff (!rst_n)
    clkEn && periphClkEn && ctrl_reg.periph_bus_divisor != 2'h0 |=> !periphClkEn)
    else $error("Peripheral enable longer than one cycle");

  AST_PLL_DIV1: assert property (
    disable iff (!rst_n)
    clkEn && pllTick && ctrl_reg.pllOutDiv == 3'h0 && !pllChange
    |=> pllClkEn)
    else $error("PLL divide by one missed a pulse");

  AST_POR_LOAD: assert property (
    !rst_n |=> ctrl_reg.pllOutDiv == $past(cfg.pllOutDiv)
           && ctrl_reg.periph_bus_divisor == $past(cfg.periph_bus_divisor))
    else $error("Reset did not load configuration bits");

  AST_FRC_DEFAULT: assert property (
    !rst_n |=> ctrl_reg.fast_rc_divider == FAST_RC_DIVIDER_RST)
    else $error("Fast RC divider reset value wrong");

  // Ready must come back on the first pulse of the new period
  AST_PB_RDY_SET: assert property (
    disable iff (!rst_n) clkEn && periphClkEn && !pbChange |=> pbRdy_reg)
    else $error("Divisor ready did not return after a pulse");

  // Outside its one cycle the read bus shows zero
  AST_RD_IDLE: assert property (
    disable iff (!rst_n) clkEn && !rdStrobe |=> rdData == '0)
    else $error("Read data stands outside its cycle");

  COV_UNLOCKED_WRITE: cover property (disable iff (!rst_n) wrCtrlOk);
  COV_PB_CHANGE: cover property (
    disable iff (!rst_n) pbChange ##[1:16] pbRdy_reg);
  COV_PB_BLOCKED: cover property (
    disable iff (!rst_n) wrCtrl && unlocked_reg && !pbRdy_reg);
  COV_UNLOCK_B2B: cover property (
    disable iff (!rst_n) wrKey ##1 wrKey ##1 unlocked_reg);
  COV_PLL_TOP: cover property (
    disable iff (!rst_n) ctrl_reg.pllOutDiv == CODE_MAX && pllClkEn);

endmodule

// *** test_oscillator_divider_control.sv ***
`timescale 1ns/1ps

module test_oscillator_divider_control
  import odc_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic              ref_clk = 1'b0;  // 20 MHz system clock
  logic              rst_n   = 1'b0;  // Synchronous reset, low
  logic              clkEn   = 1'b1;  // Held high except for one frozen write
  logic [ADDR_W-1:0] addr;            // Register address
  logic [DATA_W-1:0] wrData;          // Write data
  logic              wrStrobe;        // Write strobe
  logic              rdStrobe;        // Read strobe
  logic [DATA_W-1:0] rdData;          // Read data from the block
  odc_cfg_t          cfg;             // Configuration bits
  logic              pllTick;         // PLL source tick
  logic              frcTick;         // Fast RC source tick
  logic              secOscRunning;   // Secondary osc stable
  odc_ctrl_t         ctrlOut;         // Control fields
  logic              pllClkEn;        // Divided PLL enable
  logic              frcClkEn;        // Divided fast RC enable
  logic              periphClkEn;     // Peripheral bus enable
  logic              periphDivReady;  // Divisor write allowed
  int                mismatches;      // Failed comparisons
  int                n_compared;      // All comparisons
  logic [DATA_W-1:0] v;               // Last read value
  int                n;               // Last measured period

  // Clock: half period of 25 ns
  always #25 ref_clk = ~ref_clk;

  odc_oscillator_divider_control uut (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .clkEn          (clkEn),
    .addr           (addr),
    .wrData         (wrData),
    .wrStrobe       (wrStrobe),
    .rdStrobe       (rdStrobe),
    .rdData         (rdData),
    .cfg            (cfg),
    .pllTick        (pllTick),
    .frcTick        (frcTick),
    .secOscRunning  (secOscRunning),
    .ctrlOut        (ctrlOut),
    .pllClkEn       (pllClkEn),
    .frcClkEn       (frcClkEn),
    .periphClkEn    (periphClkEn),
    .periphDivReady (periphDivReady)
  );

  // ----------------------------------------------------------------
  // Bus tasks, checks and closing report
  // ----------------------------------------------------------------
  // One-cycle write strobe; returns at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr     <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
  endtask

  // Both keys in consecutive cycles, the tightest legal spacing
  task automatic unlock();
    @(posedge ref_clk);
    addr     <= OFS_KEY;
    wrData   <= KEY_FIRST;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrData   <= KEY_SECOND;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr     <= a;
    rdStrobe <= 1'b1;
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      mismatches++;
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Expected control image, worked out field by field
  function automatic logic [31:0] img(input logic [2:0] pd, fd,
      input logic so, ry, input logic [1:0] pb, input logic [2:0] mu, ns);
    logic [31:0] r;
    r        = 32'h0;
    r[29:27] = pd;
    r[26:24] = fd;
    r[22]    = so;
    r[21]    = ry;
    r[20:19] = pb;
    r[18:16] = mu;
    r[10:8]  = ns;
    return r;
  endfunction

  // Division factor of a code, 256 for the top code
  function automatic int fac(input int c);
    return (c == 7) ? 256 : (1 << c);
  endfunction

  function automatic logic pick(input int s);
    return (s == 0) ? pllClkEn : (s == 1) ? frcClkEn : periphClkEn;
  endfunction

  // Cycles between two enable pulses; the first gap after a restart
  // is skipped since its phase is not defined
  task automatic per(input int s, output int p);
    int i;
    p = 0;
    for (i = 0; i < 600; i++) begin
      @(posedge ref_clk);
      #1;
      if (pick(s) === 1'b1) break;
    end
    for (i = 1; i < 600; i++) begin
      @(posedge ref_clk);
      #1;
      if (pick(s) === 1'b1) begin
        p = i;
        break;
      end
    end
    if (p == 0) begin
      mismatches++;
      end_of_test();
    end
  endtask

  task automatic wait_ready();
    int i;
    for (i = 0; i < 600 && periphDivReady !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (i == 600) begin
      mismatches++;
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    addr = 8'h00; wrData = 32'h0; wrStrobe = 1'b0; rdStrobe = 1'b0;
    pllTick = 1'b1; frcTick = 1'b1; secOscRunning = 1'b0;
    cfg = '{pllOutDiv: 3'h2, pll_multiplier: 3'h5, periph_bus_divisor: 2'h3, newOscSel: 3'h4};
    mismatches = 0;
    n_compared = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Reset image: config fields, fast RC by two, holes read zero
    rd(OFS_CTRL, v);
    chk(v, img(3'h2, 3'h1, 1'b0, 1'b1, 2'h3, 3'h5, 3'h4), "reset");
    chk(32'(ctrlOut), 32'h11EC, "ctrl fields");
    per(1, n);
    chk(32'(n), 32'h2, "frc default");
    per(2, n);
    chk(32'(n), 32'h8, "pb default");
    // Ready flag follows the secondary oscillator both ways
    secOscRunning <= 1'b1;
    rd(OFS_CTRL, v);
    chk(32'(v[22]), 32'h1, "osc ready");
    // Locked write must leave every field alone
    wr(OFS_CTRL, 32'hFFFF_FFFF);
    rd(OFS_CTRL, v);
    chk(v, img(3'h2, 3'h1, 1'b1, 1'b1, 2'h3, 3'h5, 3'h4), "locked");
    rd(OFS_KEY, v);
    chk(32'(v[0]), 32'h0, "still locked");
    unlock();
    rd(OFS_KEY, v);
    chk(32'(v[0]), 32'h1, "unlocked");
    rd(8'h3C, v);
    chk(v, 32'h0, "unmapped");
    // Frozen clock enable: an unlocked write must not land
    clkEn <= 1'b0;
    wr(OFS_CTRL, img(3'h0, 3'h0, 1'b0, 1'b0, 2'h3, 3'h5, 3'h4));
    clkEn <= 1'b1;
    rd(OFS_CTRL, v);
    chk(v, img(3'h2, 3'h1, 1'b1, 1'b1, 2'h3, 3'h5, 3'h4), "frozen");
    // Every post-divider and fast RC code; ones in the holes too
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CTRL, img(3'(c), 3'(c), 1'b0, 1'b0, 2'h3, 3'h5, 3'h4)
                   | 32'hC080_0000);
      rd(OFS_CTRL, v);
      chk(v, img(3'(c), 3'(c), 1'b1, 1'b1, 2'h3, 3'h5, 3'h4), "img");
      per(0, n);
      chk(32'(n), 32'(fac(c)), "pll period");
      per(1, n);
      chk(32'(n), 32'(fac(c)), "frc period");
    end
    // Every peripheral divisor; a write while not ready is dropped
    for (int p = 0; p < 4; p++) begin
      wr(OFS_CTRL, img(3'h0, 3'h0, 1'b0, 1'b0, 2'(p), 3'h5, 3'h4));
      #1;
      chk(32'(periphDivReady), 32'h0, "ready drops");
      if (p == 3) begin
        wr(OFS_CTRL, img(3'h0, 3'h0, 1'b0, 1'b0, 2'h0, 3'h5, 3'h4));
      end
      wait_ready();
      rd(OFS_CTRL, v);
      chk(32'(v[20:19]), 32'(p), "pb field");
      per(2, n);
      chk(32'(n), 32'(fac(p)), "pb period");
    end
    secOscRunning <= 1'b0;
    rd(OFS_CTRL, v);
    chk(32'(v[22]), 32'h0, "osc off");
    end_of_test();
  end

endmodule
